// *** include/tmr2_defines.vh ***
// constants for the sixteen-bit capture/reload/baud timer
// Notes on behaviour
// - 16-bit count, osc/12 or external falling edges
// - overflow sets bit 7 until software clears
// - no overflow flag while any clock select set
// - trigger capture/reload sets bit 6 flag
// - set external flag raises interrupt only while bit 2 runs
// - bit 5 steers receive clock to overflow
// - bit 4 steers transmit clock to overflow
// - bit 3 enables trigger unless in baud mode
// - bit 2 runs timer, zero stops it
// - select 1: trigger edge captures count
// - select 0: reload on overflow and trigger
// - baud mode forces auto-reload, ignores select
// - mode decode from selects and run bit
// - reload loads count from capture/reload pair
// - both flags share one interrupt request
`ifndef TMR2_DEFINES_VH
`define TMR2_DEFINES_VH
`define TMR2_CTRL_ADDR     8'hc8
`define TMR2_CNT_LO_ADDR   8'hcc
`define TMR2_CNT_HI_ADDR   8'hcd
`define TMR2_CAP_LO_ADDR   8'hca
`define TMR2_CAP_HI_ADDR   8'hcb
`define TMR2_CTRL_RESET    8'h00
`define TMR2_BIT_OVF       7
`define TMR2_BIT_EXT       6
`define TMR2_BIT_RXSEL     5
`define TMR2_BIT_TXSEL     4
`define TMR2_BIT_EXEN      3
`define TMR2_BIT_RUN       2
`define TMR2_BIT_SRC       1
`define TMR2_BIT_CAPSEL    0
`define TMR2_PRESCALE      4'hb
`endif

// *** verilog/tmr2_fall_detect.v ***
// two-stage synchroniser with falling edge pulse
`timescale 1ns/1ps
module tmr2_fall_detect
(
  mclk,
  resetn,
  pin_in,
  fall_pulse
);
  input  wire mclk;
  input  wire resetn;
  input  wire pin_in;
  output reg  fall_pulse;

  reg meta_reg;
  reg sync_reg;
  reg prev_reg;

  // pins idle high, so reset to one avoids a false edge
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      meta_reg   <= 1'b1;
      sync_reg   <= 1'b1;
      prev_reg   <= 1'b1;
      fall_pulse <= 1'b0;
    end
    else
    begin
      meta_reg   <= pin_in;
      sync_reg   <= meta_reg;
      prev_reg   <= sync_reg;
      fall_pulse <= prev_reg & ~sync_reg;
    end
  end
endmodule

// *** verilog/tmr2_top.v ***
// sixteen-bit timer with auto-reload, capture and baud modes
`timescale 1ns/1ps
`include "tmr2_defines.vh"
module tmr2_top
(
  mclk,
  resetn,
  sfr_addr,
  sfr_wdata,
  sfr_wr,
  sfr_rd,
  sfr_rdata,
  count_pin,
  trigger_pin,
  t1_overflow,
  rx_baud_tick,
  tx_baud_tick,
  irq_req
);
  input  wire       mclk;
  input  wire       resetn;
  input  wire [7:0] sfr_addr;
  input  wire [7:0] sfr_wdata;
  input  wire       sfr_wr;
  input  wire       sfr_rd;
  output reg  [7:0] sfr_rdata;
  input  wire       count_pin;
  input  wire       trigger_pin;
  input  wire       t1_overflow;
  output reg        rx_baud_tick;
  output reg        tx_baud_tick;
  output reg        irq_req;

  localparam [2:0] MODE_STOP = 3'b001;
  localparam [2:0] MODE_LOAD = 3'b010;
  localparam [2:0] MODE_CAPT = 3'b100;

  reg  [7:0]  ctrl_reg;
  reg  [7:0]  ctrl_next;
  reg  [15:0] count_reg;
  reg  [15:0] count_next;
  reg  [15:0] cap_reg;
  reg  [15:0] cap_next;
  reg  [3:0]  pre_reg;
  reg  [3:0]  pre_next;
  reg  [2:0]  mode;
  reg         tick;
  reg         ovf;
  wire        count_fall;
  wire        trig_fall;
  wire        baud;
  wire        trig_ok;

  ////////////////////////////////////////////////////////////////////////
  // pin edge detection
  tmr2_fall_detect u_count_edge
  (
    .mclk       (mclk),
    .resetn     (resetn),
    .pin_in     (count_pin),
    .fall_pulse (count_fall)
  );

  tmr2_fall_detect u_trig_edge
  (
    .mclk       (mclk),
    .resetn     (resetn),
    .pin_in     (trigger_pin),
    .fall_pulse (trig_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  assign baud    = ctrl_reg[`TMR2_BIT_RXSEL] | ctrl_reg[`TMR2_BIT_TXSEL];
  // baud mode blocks trigger events entirely
  assign trig_ok = trig_fall & ctrl_reg[`TMR2_BIT_EXEN] & ~baud;

  always @*
  begin
    if (!ctrl_reg[`TMR2_BIT_RUN])
      mode = MODE_STOP;
    else if (baud | ~ctrl_reg[`TMR2_BIT_CAPSEL])
      mode = MODE_LOAD;
    else
      mode = MODE_CAPT;
  end

  ////////////////////////////////////////////////////////////////////////
  // count source and overflow
  always @*
  begin
    pre_next = (pre_reg == `TMR2_PRESCALE) ? 4'h0 : pre_reg + 4'h1;
    if (ctrl_reg[`TMR2_BIT_SRC])
      tick = count_fall;
    else
      tick = (pre_reg == `TMR2_PRESCALE);
    case (mode)
      MODE_STOP: ovf = 1'b0;
      MODE_LOAD: ovf = tick & (count_reg == 16'hffff);
      MODE_CAPT: ovf = tick & (count_reg == 16'hffff);
      default:   ovf = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // counter, capture register and control next state
  always @*
  begin
    count_next = count_reg;
    cap_next   = cap_reg;
    ctrl_next  = ctrl_reg;
    if (sfr_wr && sfr_addr == `TMR2_CTRL_ADDR)
      ctrl_next = sfr_wdata;
    if (sfr_wr && sfr_addr == `TMR2_CAP_LO_ADDR)
      cap_next[7:0] = sfr_wdata;
    if (sfr_wr && sfr_addr == `TMR2_CAP_HI_ADDR)
      cap_next[15:8] = sfr_wdata;
    if (sfr_wr && sfr_addr == `TMR2_CNT_LO_ADDR)
      count_next[7:0] = sfr_wdata;
    if (sfr_wr && sfr_addr == `TMR2_CNT_HI_ADDR)
      count_next[15:8] = sfr_wdata;
    case (mode)
      MODE_LOAD:
      begin
        if (ovf | trig_ok)
          count_next = cap_reg;
        else if (tick)
          count_next = count_reg + 16'h0001;
      end
      MODE_CAPT:
      begin
        if (tick)
          count_next = count_reg + 16'h0001;
        if (trig_ok)
          cap_next = count_reg;
      end
      default:
        count_next = count_next;
    endcase
    // capture/reload triggers still flag with the timer stopped
    if (mode == MODE_STOP && trig_ok && ctrl_reg[`TMR2_BIT_CAPSEL])
      cap_next = count_reg;
    // hardware set wins over a same-cycle software clear
    if (ovf && !baud)
      ctrl_next[`TMR2_BIT_OVF] = 1'b1;
    if (trig_ok)
      ctrl_next[`TMR2_BIT_EXT] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and outputs
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      ctrl_reg     <= `TMR2_CTRL_RESET;
      count_reg    <= 16'h0000;
      cap_reg      <= 16'h0000;
      pre_reg      <= 4'h0;
      rx_baud_tick <= 1'b0;
      tx_baud_tick <= 1'b0;
      irq_req      <= 1'b0;
      sfr_rdata    <= 8'h00;
    end
    else
    begin
      ctrl_reg     <= ctrl_next;
      count_reg    <= count_next;
      cap_reg      <= cap_next;
      pre_reg      <= pre_next;
      rx_baud_tick <= ctrl_reg[`TMR2_BIT_RXSEL] ? ovf : t1_overflow;
      tx_baud_tick <= ctrl_reg[`TMR2_BIT_TXSEL] ? ovf : t1_overflow;
      // one request line, service routine tests both flags
      irq_req      <= ctrl_next[`TMR2_BIT_OVF] |
                      (ctrl_next[`TMR2_BIT_EXT] & ctrl_next[`TMR2_BIT_RUN]);
      if (sfr_rd)
      begin
        case (sfr_addr)
          `TMR2_CTRL_ADDR:   sfr_rdata <= ctrl_reg;
          `TMR2_CAP_LO_ADDR: sfr_rdata <= cap_reg[7:0];
          `TMR2_CAP_HI_ADDR: sfr_rdata <= cap_reg[15:8];
          `TMR2_CNT_LO_ADDR: sfr_rdata <= count_reg[7:0];
          `TMR2_CNT_HI_ADDR: sfr_rdata <= count_reg[15:8];
          default:           sfr_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// *** dv/tmr2_serial_model.sv ***
// far side: timer 1 overflow source and serial clock tally
`timescale 1ns/1ps
module tmr2_serial_model
(
  input  wire        mclk,
  input  wire        clr,
  input  wire        rx_baud_tick,
  input  wire        tx_baud_tick,
  output reg         t1_overflow,
  output reg  [15:0] tick_cnt
);
  reg [2:0] div_reg = 3'h0;
  initial t1_overflow = 1'b0;
  initial tick_cnt = 16'h0000;
  always @(posedge mclk)
  begin
    div_reg <= div_reg + 3'h1;
    t1_overflow <= #1 div_reg == 3'h0;
    tick_cnt <= clr ? 16'h0000 : tick_cnt + rx_baud_tick + tx_baud_tick;
  end
endmodule

// *** dv/tmr2_top_assertions.sv ***
// port checker for the timer
`timescale 1ns/1ps
module tmr2_top_assertions
(
  input wire       mclk,
  input wire       resetn,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire       sfr_wr,
  input wire       sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire       trigger_pin,
  input wire       t1_overflow,
  input wire       rx_baud_tick,
  input wire       tx_baud_tick,
  input wire       irq_req
);
  reg [5:0] c_reg;
  reg       b_reg;
  // software bits only, flags move under hardware
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      c_reg <= 6'h00;
      b_reg <= 1'b0;
    end
    else if (sfr_wr && sfr_addr == 8'hc8)
    begin
      c_reg <= sfr_wdata[5:0];
      b_reg <= |sfr_wdata[5:4] && ~|sfr_wdata[7:6];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_trig; $fell(trigger_pin) && c_reg[3:2] == 2'h3 && c_reg[5:4] == 2'h0; endsequence
  sequence s_rdc; sfr_rd && sfr_addr == 8'hc8; endsequence
  property p_rx; !c_reg[5] |=> rx_baud_tick == $past(t1_overflow); endproperty
  a_rx: assert property (p_rx) else $error("rx");
  property p_tx; !c_reg[4] |=> tx_baud_tick == $past(t1_overflow); endproperty
  a_tx: assert property (p_tx) else $error("tx");
  property p_stop; (c_reg[5] && !c_reg[2])[*4] |-> !rx_baud_tick; endproperty
  a_stop: assert property (p_stop) else $error("stop");
  property p_one; rx_baud_tick && c_reg[5] |=> !rx_baud_tick; endproperty
  a_one: assert property (p_one) else $error("one");
  property p_onet; tx_baud_tick && c_reg[4] |=> !tx_baud_tick; endproperty
  a_onet: assert property (p_onet) else $error("onet");
  property p_irq; s_rdc |=> !sfr_rdata[7] || irq_req; endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_nof; b_reg[*3] |-> !irq_req; endproperty
  a_nof: assert property (p_nof) else $error("nof");
  property p_ext; s_trig |-> ##[2:8] irq_req; endproperty
  a_ext: assert property (p_ext) else $error("ext");
endmodule
bind tmr2_top tmr2_top_assertions tmr2_top_assertions_inst (.mclk(mclk), .resetn(resetn), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .trigger_pin(trigger_pin),
  .t1_overflow(t1_overflow), .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick), .irq_req(irq_req));

// *** dv/tmr2_top_tb_top.sv ***
// self-checking bench for the timer
`timescale 1ns/1ps
module tmr2_top_tb_top;
  reg         mclk = 0, resetn = 0, sfr_wr = 0, sfr_rd = 0, count_pin = 1, trigger_pin = 1, clr = 0, p = 0;
  reg  [7:0]  sfr_addr = 0, sfr_wdata = 0, h;
  reg  [15:0] q, exq[$];
  wire [7:0]  sfr_rdata;
  wire        t1_overflow, rx_baud_tick, tx_baud_tick, irq_req;
  wire [15:0] tick_cnt;
  integer     err_total = 0, checked = 0, i;
  always #4 mclk = ~mclk;
  tmr2_top tmr2_top_inst (.mclk(mclk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .count_pin(count_pin), .trigger_pin(trigger_pin),
    .t1_overflow(t1_overflow), .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick), .irq_req(irq_req));
  tmr2_serial_model tmr2_serial_model_inst (.mclk(mclk), .clr(clr), .rx_baud_tick(rx_baud_tick),
    .tx_baud_tick(tx_baud_tick), .t1_overflow(t1_overflow), .tick_cnt(tick_cnt));
  task cyc(input integer n);
  begin
    repeat (n) @(posedge mclk);
    #1;
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    cyc(1);
    sfr_wr = 0;
    // idle edge so back-to-back writes never re-raise the strobe in one step
    cyc(1);
  end
  endtask
  task rd(input [7:0] a, input [7:0] d);
  begin
    sfr_addr = a;
    exq.push_back({8'h00, d});
    sfr_rd = 1;
    cyc(1);
    sfr_rd = 0;
    cyc(1);
  end
  endtask
  task chk(input [39:0] nm, input [15:0] e, input [15:0] s);
  begin
    checked = checked + 1;
    if (e !== s)
    begin
      err_total = err_total + 1;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  end
  endtask
  task print_verdict;
  begin
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // read data lands one cycle after the read edge
  always @(posedge mclk)
  begin
    #2;
    if (p)
    begin
      q = exq.pop_front();
      chk("rdata", q, {8'h00, sfr_rdata});
    end
    p = sfr_rd;
  end
  initial
  begin
    cyc(5000);
    err_total = err_total + 1;
    print_verdict;
  end
  initial
  begin
    i = $urandom(32'h701677be);
    h = 8'h01 + 8'($urandom % 254);
    cyc(6);
    resetn = 1;
    rd(8'hc8, 8'h00);
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hff);
    wr(8'hca, 8'h00);
    wr(8'hcb, h);
    wr(8'hc8, 8'h04);
    cyc(40);
    wr(8'hc8, 8'h80);
    rd(8'hc8, 8'h80);
    chk("irq", 16'h0001, {15'h0000, irq_req});
    rd(8'hcd, h);
    wr(8'hcb, 8'h00);
    wr(8'hc8, 8'h0d);
    trigger_pin = 0;
    cyc(10);
    wr(8'hc8, 8'h49);
    trigger_pin = 1;
    rd(8'hc8, 8'h49);
    chk("irqst", 16'h0000, {15'h0000, irq_req});
    rd(8'hcb, h);
    for (i = 0; i < 4; i = i + 1)
      wr(8'hca + i[7:0], 8'hff);
    wr(8'hc8, 8'h3c);
    for (i = 0; i < 30; i = i + 1)
    begin
      trigger_pin = ^$urandom;
      cyc(4);
    end
    wr(8'hc8, 8'h38);
    trigger_pin = 1;
    rd(8'hc8, 8'h38);
    clr = 1;
    cyc(1);
    clr = 0;
    wr(8'hc8, 8'h37);
    for (i = 0; i < 14; i = i + 1)
    begin
      if (i == 10)
        wr(8'hc8, 8'h33);
      count_pin = 0;
      cyc(4);
      count_pin = 1;
      cyc(4);
    end
    chk("ticks", 16'h0014, tick_cnt);
    print_verdict;
  end
endmodule
